// >>> core/rail_seq_defs.svh
// Timing counts, widths and channel count for the quad rail sequencer
`ifndef RAIL_SEQ_DEFS_SVH
`define RAIL_SEQ_DEFS_SVH
`define RSEQ_TIMER_W 24
`define RSEQ_STEP_DLY_CYC 24'd10000
`define RSEQ_BLANK_CYC 24'd10000
`define RSEQ_HOLD_CYC 24'd5000
`define RSEQ_RDY_DLY_MS 0.5
`define RSEQ_CLK_MHZ 10
`define RSEQ_RDY_DLY_CYC (`RSEQ_RDY_DLY_MS * `RSEQ_CLK_MHZ * 1000)
`define RSEQ_NCH 4
`endif

// >>> core/rail_seq_pkg.sv
// Types for the quad rail sequencer
package rail_seq_pkg;
  typedef enum logic [4:0] {
    ST_SET_FAULT = 5'h00,
    ST_CLR_FAULT = 5'h01,
    ST_WAIT_OK = 5'h03,
    ST_IDLE = 5'h02,
    ST_DLY = 5'h06,
    ST_ENA = 5'h07,
    ST_BLANK = 5'h05,
    ST_DONE = 5'h04,
    ST_DIS = 5'h0c,
    ST_DIS_DLY = 5'h0d
  } seq_state_e;
endpackage

// >>> core/sync_edge.sv
// Two-stage synchroniser with edge detection for an asynchronous input
`timescale 1ns/1ns
module sync_edge (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic asyncIn,
  input wire logic resetVal,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= asyncIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~prev_r & ~resetVal;
  assign fall = ~sync_r & prev_r & ~resetVal;
endmodule

// >>> core/quad_rail_up_down_sequencer.sv
// Quad supply up/down sequencer with rail monitoring and fault handling
`timescale 1ns/1ns
`include "rail_seq_defs.svh"
module quad_rail_up_down_sequencer #(
  parameter bit REDUCED = 1'b0,
  parameter logic [`RSEQ_TIMER_W-1:0] STEP1_CYC = `RSEQ_STEP_DLY_CYC,
  parameter logic [`RSEQ_TIMER_W-1:0] STEP2_CYC = `RSEQ_STEP_DLY_CYC,
  parameter logic [`RSEQ_TIMER_W-1:0] STEP3_CYC = `RSEQ_STEP_DLY_CYC,
  parameter logic [`RSEQ_TIMER_W-1:0] STEP4_CYC = `RSEQ_STEP_DLY_CYC,
  parameter logic [`RSEQ_TIMER_W-1:0] BLANK_CYC = `RSEQ_BLANK_CYC,
  parameter logic [`RSEQ_TIMER_W-1:0] HOLD_CYC = `RSEQ_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic supplyLockout,
  input wire logic [3:0] railThresholdFlag,
  input wire logic seqUp,
  input wire logic seqDown,
  input wire logic faultLineIn,
  output logic faultLineOut,
  output logic faultLineOe,
  output logic [3:0] supplyEnableLine,
  output logic allRailsGood,
  output logic sequenceComplete,
  output rail_seq_pkg::seq_state_e seqState
);
  import rail_seq_pkg::*;

  typedef struct packed {
    seq_state_e st;
    logic [1:0] ch;
    logic [`RSEQ_TIMER_W-1:0] tmr;
    logic [3:0] ena;
    logic done;
    logic faultDrv;
    logic good;
  } core_s;

  core_s cur_r;
  core_s cur_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [3:0] railLvl;
  logic upLvl;
  logic upRise;
  logic dnFall;
  logic fltLvl;
  logic lockLvl;
  logic lockMeta_r;
  logic lockSync_r;

  // Rail flags need only their level; their edges are left unused
  genvar g;
  generate
    for (g = 0; g < `RSEQ_NCH; g++) begin : gRail
      sync_edge uRail (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .asyncIn(railThresholdFlag[g]),
        .resetVal(1'b0),
        .level(railLvl[g]),
        .rise(),
        .fall()
      );
    end
  endgenerate

  // Edges are masked in lockout so none is carried over into the machine
  sync_edge uUp (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .asyncIn(seqUp),
    .resetVal(lockLvl),
    .level(upLvl),
    .rise(upRise),
    .fall()
  );

  // Reduced variant has one combined up/down input
  sync_edge uDn (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .asyncIn(REDUCED ? seqUp : seqDown),
    .resetVal(lockLvl),
    .level(),
    .rise(),
    .fall(dnFall)
  );

  sync_edge uFlt (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .asyncIn(faultLineIn),
    .resetVal(1'b0),
    .level(fltLvl),
    .rise(),
    .fall()
  );

  // Reset reads as lockout so the machine stays held until the pin is sampled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lockMeta_r <= 1'b1;
      lockSync_r <= 1'b1;
    end else begin
      lockMeta_r <= supplyLockout;
      lockSync_r <= lockMeta_r;
    end
  end
  assign lockLvl = lockSync_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic [`RSEQ_TIMER_W-1:0] stepCyc;
  logic [`RSEQ_TIMER_W-1:0] nextStepCyc;
  logic extFault;
  logic tmrZero;

  // Step delay reload of the present channel, used on the way down
  always_comb begin
    case (cur_r.ch)
      2'd0: stepCyc = STEP1_CYC;
      2'd1: stepCyc = STEP2_CYC;
      2'd2: stepCyc = STEP3_CYC;
      default: stepCyc = STEP4_CYC;
    endcase
  end

  // Reload for the step delay that follows the channel just verified
  always_comb begin
    case (cur_r.ch)
      2'd0: nextStepCyc = STEP2_CYC;
      2'd1: nextStepCyc = STEP3_CYC;
      default: nextStepCyc = STEP4_CYC;
    endcase
  end

  assign tmrZero = (cur_r.tmr == '0);
  // Our own pull on the shared line must not read back as an outside fault
  assign extFault = ~REDUCED & ~fltLvl & ~cur_r.faultDrv;

  ////////////////////////////////////////////////////////////////////////
  // Fault causes
  logic [3:0] chMask;
  logic [3:0] railLost;
  logic [3:0] railLostOld;
  logic railUpFault;
  logic railDoneFault;
  logic railDownFault;

  // The channel inside its blanking interval is judged only when it ends
  assign chMask = 4'h1 << cur_r.ch;
  assign railLost = cur_r.ena & ~railLvl;
  assign railLostOld = railLost & ~chMask;
  // In a step delay every enabled rail has already passed blanking
  assign railUpFault = (cur_r.st == ST_DLY) ? (railLost != 4'h0) : (railLostOld != 4'h0);
  assign railDoneFault = ~(&railLvl);
  // Rails already switched off are no longer watched
  assign railDownFault = (railLost != 4'h0);

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.good = &railLvl;
    // Timer counts down to zero and rests there
    if (cur_r.tmr != '0) begin
      cur_nxt.tmr = cur_r.tmr - 1'b1;
    end
    case (cur_r.st)
      ST_SET_FAULT: begin
        cur_nxt.ena = 4'h0;
        cur_nxt.done = 1'b0;
        cur_nxt.faultDrv = ~REDUCED;
        if (tmrZero) begin
          cur_nxt.st = ST_CLR_FAULT;
        end
      end
      ST_CLR_FAULT: begin
        // An up input still high stretches the fault hold
        if (!upLvl) begin
          cur_nxt.st = ST_WAIT_OK;
          cur_nxt.faultDrv = 1'b0;
        end
      end
      ST_WAIT_OK: begin
        if (REDUCED || fltLvl) begin
          cur_nxt.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        cur_nxt.done = 1'b0;
        cur_nxt.ch = 2'd0;
        if (upRise) begin
          cur_nxt.tmr = STEP1_CYC;
          cur_nxt.st = REDUCED ? ST_ENA : ST_DLY;
        end
      end
      ST_DLY: begin
        if (tmrZero) begin
          cur_nxt.st = ST_ENA;
        end
      end
      ST_ENA: begin
        // Blanking starts together with the enable
        cur_nxt.ena[cur_r.ch] = 1'b1;
        cur_nxt.tmr = BLANK_CYC;
        cur_nxt.st = ST_BLANK;
      end
      ST_BLANK: begin
        if (tmrZero) begin
          if (!railLvl[cur_r.ch]) begin
            cur_nxt.st = ST_SET_FAULT;
          end else if (cur_r.ch == 2'd3) begin
            cur_nxt.st = ST_DONE;
            cur_nxt.done = ~REDUCED;
          end else begin
            cur_nxt.ch = cur_r.ch + 2'd1;
            cur_nxt.tmr = nextStepCyc;
            cur_nxt.st = ST_DLY;
          end
        end
      end
      ST_DONE: begin
        if (dnFall) begin
          cur_nxt.ena[3] = 1'b0;
          cur_nxt.tmr = STEP4_CYC;
          cur_nxt.st = ST_DIS_DLY;
        end
      end
      ST_DIS: begin
        // Disable one channel, then wait that channel's own step delay, except channel 0 in the reduced variant, which goes straight to idle
        cur_nxt.ena[cur_r.ch] = 1'b0;
        cur_nxt.tmr = stepCyc;
        cur_nxt.st = (REDUCED && cur_r.ch == 2'd0) ? ST_IDLE : ST_DIS_DLY;
      end
      ST_DIS_DLY: begin
        if (tmrZero) begin
          if (cur_r.ch == 2'd0) begin
            cur_nxt.st = ST_IDLE;
          end else begin
            cur_nxt.ch = cur_r.ch - 2'd1;
            cur_nxt.st = ST_DIS;
          end
        end
      end
      default: begin
        cur_nxt.st = ST_SET_FAULT;
      end
    endcase

    // Fault detection overrides any step above
    case (cur_r.st)
      ST_IDLE: begin
        if (dnFall || extFault) begin
          cur_nxt.st = ST_SET_FAULT;
        end
      end
      ST_DLY, ST_ENA, ST_BLANK: begin
        if (dnFall || extFault || railUpFault) begin
          cur_nxt.st = ST_SET_FAULT;
        end
      end
      ST_DONE: begin
        if (railDoneFault || (!REDUCED && upRise) || extFault) begin
          cur_nxt.st = ST_SET_FAULT;
        end
      end
      ST_DIS, ST_DIS_DLY: begin
        if (railDownFault || upRise || extFault) begin
          cur_nxt.st = ST_SET_FAULT;
        end
      end
      default: begin
        // Fault states and waits judge nothing here
      end
    endcase
    if (cur_nxt.st == ST_SET_FAULT && cur_r.st != ST_SET_FAULT) begin
      cur_nxt.tmr = HOLD_CYC;
      cur_nxt.ena = 4'h0;
      cur_nxt.done = 1'b0;
      cur_nxt.faultDrv = ~REDUCED;
    end
    // Done falls on the very edge that returns to idle
    if (cur_nxt.st == ST_IDLE) begin
      cur_nxt.done = 1'b0;
    end
    // Lockout wins over every other cause
    if (lockLvl) begin
      cur_nxt.st = ST_SET_FAULT;
      cur_nxt.good = 1'b0;
      cur_nxt.tmr = HOLD_CYC;
      cur_nxt.ena = 4'h0;
      cur_nxt.done = 1'b0;
      cur_nxt.faultDrv = 1'b0;
      cur_nxt.ch = 2'd0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_r <= '{st: ST_SET_FAULT, ch: 2'd0, tmr: '0, ena: 4'h0,
                 done: 1'b0, faultDrv: 1'b0, good: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // All outputs but faultLineOut come straight from the state register
  assign supplyEnableLine = cur_r.ena;
  assign sequenceComplete = cur_r.done;
  assign faultLineOe = cur_r.faultDrv;
  // Open-drain data: the pin only ever pulls low
  assign faultLineOut = 1'b0;
  assign allRailsGood = cur_r.good;
  assign seqState = cur_r.st;
endmodule

// >>> dv/quad_rail_up_down_sequencer_assertions.sv
// Port-level checker for the quad rail sequencer
`timescale 1ns/1ns
module quad_rail_up_down_sequencer_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic supplyLockout,
  input wire logic [3:0] railThresholdFlag,
  input wire logic seqUp,
  input wire logic seqDown,
  input wire logic faultLineIn,
  input wire logic faultLineOut,
  input wire logic faultLineOe,
  input wire logic [3:0] supplyEnableLine,
  input wire logic allRailsGood,
  input wire logic sequenceComplete,
  input wire rail_seq_pkg::seq_state_e seqState
);
  import rail_seq_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  sequence lockHeld; supplyLockout [*6]; endsequence
  sequence railsSettled; (!supplyLockout && $stable(railThresholdFlag)) [*6]; endsequence
  sequence faultHeld; (!supplyLockout && seqState == ST_SET_FAULT) [*6]; endsequence
  sequence stays(seq_state_e s); $past(seqState) == s && seqState == s; endsequence
  ////////////////////////////////////////
  AST_LOCK_OFF: assert property (lockHeld |-> seqState == ST_SET_FAULT &&
    supplyEnableLine == 4'h0 && !sequenceComplete) else $error("lockout outputs");
  AST_RAILS_AND: assert property (railsSettled |-> allRailsGood == &railThresholdFlag)
    else $error("rails good mismatch");
  AST_FAULT_OUT: assert property (faultHeld |-> supplyEnableLine == 4'h0 &&
    !sequenceComplete && faultLineOe) else $error("fault outputs");
  AST_DONE_OUT: assert property (stays(ST_DONE) |-> sequenceComplete &&
    supplyEnableLine == 4'hf) else $error("done outputs");
  AST_IDLE_OUT: assert property (stays(ST_IDLE) |-> !sequenceComplete &&
    supplyEnableLine == 4'h0 && !faultLineOe) else $error("idle outputs");
  AST_DOWN_FIRST: assert property ($fell(seqState == ST_DONE) &&
    seqState != ST_SET_FAULT |-> ##[0:2] supplyEnableLine == 4'h7) else $error("down order");
  AST_ENA_FIRST: assert property ($rose(supplyEnableLine[0]) |-> $past(seqState) == ST_ENA)
    else $error("enable one early");
  AST_RAIL_DROP: assert property (seqState == ST_DONE && railThresholdFlag != 4'hf
    |-> ##[1:5] seqState == ST_SET_FAULT) else $error("rail drop ignored");
  AST_EXT_FAULT: assert property (seqState == ST_DONE && !faultLineIn
    |-> ##[1:5] seqState == ST_SET_FAULT) else $error("external fault ignored");
  AST_WAIT_HOLD: assert property ((seqState == ST_WAIT_OK && !faultLineIn) [*3]
    |=> seqState != ST_IDLE) else $error("left wait early");
  AST_IDLE_DONE: assert property (seqState == ST_IDLE |-> !sequenceComplete)
    else $error("done high in idle");
endmodule

bind quad_rail_up_down_sequencer quad_rail_up_down_sequencer_assertions
  quad_rail_up_down_sequencer_assertions_i (.*);

// >>> dv/rail_model.sv
// Regulator stand-ins: each rail rises two cycles after its enable
`timescale 1ns/1ns
module rail_model (
  input wire logic clk_sys,
  input wire logic [3:0] enable,
  input wire logic [3:0] stuckLow,
  output logic [3:0] railFlag
);
  logic [3:0] stage1_r;
  logic [3:0] stage2_r;
  always_ff @(posedge clk_sys) begin
    stage1_r <= enable;
    stage2_r <= stage1_r & enable;
  end
  // A stuck rail never reaches threshold, or collapses while on
  assign railFlag = stage2_r & enable & ~stuckLow;
endmodule

// >>> dv/quad_rail_up_down_sequencer_tb.sv
// Self-checking bench for the quad rail sequencer
`timescale 1ns/1ns
module quad_rail_up_down_sequencer_tb;
  import rail_seq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic supplyLockout = 1'b1;
  logic seqUp = 1'b0;
  logic seqDown = 1'b1;
  logic extPull = 1'b0;
  logic [3:0] stuckLow = 4'h0;
  logic [3:0] railThresholdFlag;
  logic [3:0] supplyEnableLine;
  logic faultLineOut;
  logic faultLineOe;
  logic allRailsGood;
  logic sequenceComplete;
  seq_state_e seqState;
  int mismatches = 0;
  int n_checks = 0;
  // Open-drain fault wire with pull-up
  wire logic faultWire = !((faultLineOe && !faultLineOut) || extPull);
  // Hold time stays at its default reload
  quad_rail_up_down_sequencer #(.STEP1_CYC(24'h4), .STEP2_CYC(24'h4), .STEP3_CYC(24'h4),
    .STEP4_CYC(24'h4), .BLANK_CYC(24'h6)) quad_rail_up_down_sequencer_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .supplyLockout(supplyLockout),
    .railThresholdFlag(railThresholdFlag), .seqUp(seqUp), .seqDown(seqDown),
    .faultLineIn(faultWire), .faultLineOut(faultLineOut), .faultLineOe(faultLineOe),
    .supplyEnableLine(supplyEnableLine), .allRailsGood(allRailsGood),
    .sequenceComplete(sequenceComplete), .seqState(seqState));
  rail_model rail_model_i (.clk_sys(clk_sys), .enable(supplyEnableLine),
    .stuckLow(stuckLow), .railFlag(railThresholdFlag));
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [4:0] s, input logic [4:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic waitSt(input seq_state_e s);
    int i;
    for (i = 0; i < 6000 && seqState !== s; i++) cyc(1);
    chk("state", seqState, s);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_boot;
    cyc(10);
    chk("lockState", seqState, ST_SET_FAULT);
    chk("lockEna", 5'(supplyEnableLine), 5'h0);
    extPull = 1'b1;
    supplyLockout = 1'b0;
    waitSt(ST_WAIT_OK);
    chk("oeWait", 5'(faultLineOe), 5'h0);
    cyc(20);
    chk("holdWait", seqState, ST_WAIT_OK);
    extPull = 1'b0;
    waitSt(ST_IDLE);
  endtask
  task automatic t_up;
    seqUp = 1'b1;
    waitSt(ST_DLY);
    waitSt(ST_DONE);
    chk("upEna", 5'(supplyEnableLine), 5'hf);
    chk("upDone", 5'(sequenceComplete), 5'h1);
    chk("pgood", 5'(allRailsGood), 5'h1);
  endtask
  task automatic t_down;
    logic [3:0] e;
    int i;
    int j;
    e = 4'hf;
    seqDown = 1'b0;
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 50 && supplyEnableLine === e; j++) cyc(1);
      e = e >> 1;
      chk("downEna", 5'(supplyEnableLine), 5'(e));
    end
    waitSt(ST_IDLE);
    chk("downDone", 5'(sequenceComplete), 5'h0);
    seqDown = 1'b1;
    seqUp = 1'b0;
    cyc(4);
  endtask
  task automatic t_fault(input int kind);
    if (kind == 0) begin
      seqDown = 1'b0;
    end else begin
      stuckLow = kind == 1 ? 4'h4 : 4'h0;
      seqUp = 1'b1;
      if (kind > 1) waitSt(ST_DONE);
      if (kind == 2) stuckLow = 4'h2;
      if (kind == 3) extPull = 1'b1;
      if (kind == 4 || kind == 5) begin
        seqDown = kind == 4;
        seqUp = 1'b0;
        cyc(6);
        seqUp = 1'b1;
      end
      if (kind == 6) begin
        seqDown = 1'b0;
        cyc(2);
        stuckLow = 4'h1;
      end
    end
    waitSt(ST_SET_FAULT);
    chk("fltEna", 5'(supplyEnableLine), 5'h0);
    chk("fltOe", 5'(faultLineOe), 5'h1);
    chk("fltOut", 5'(faultLineOut), 5'h0);
    chk("fltDone", 5'(sequenceComplete), 5'h0);
    {seqUp, seqDown, extPull, stuckLow} = 7'h20;
    waitSt(ST_IDLE);
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(8);
    rst_b = 1'b1;
    t_boot();
    t_up();
    t_down();
    for (int k = 0; k < 7; k++) t_fault(k);
    t_up();
    finish_test();
  end
  initial begin
    #6000000;
    mismatches++;
    finish_test();
  end
endmodule
